// ---- rtl/fractional_word_registers.sv ----
// Purpose: Double buffered main fraction, aux modulus and aux fraction words
// Assumes: 3-wire link, word taken on the rising latch enable
// Notes:   Link word crosses as a held bus qualified by a synced latch enable
//
// Operation
// - Select 0001 loads main fraction bits 27:4
// - Main and aux fraction form numerator
// - Select 0010 writes aux modulus register
// - Aux modulus is fourteen bits 17:4
// - Aux modulus is second stage denominator
// - Select 0011 writes aux fraction register
// - Aux fraction fourteen bits 17:4 to stage
// - Buffered values apply on register 0 write
`timescale 1ns/1ps
`include "fractional_word_consts.svh"

module fractional_word_registers
   import fractional_word_pkg::*;
#(
   parameter int MAIN_FRAC_W = 24,
   parameter int AUX_W = 14
) (
   // System
   input wire logic sys_clk,
   input wire logic rst,
   // 3-wire link
   input wire logic serialClock,
   input wire logic serialData,
   input wire logic latchEnable,
   // Active words to the modulator
   output logic [MAIN_FRAC_W-1:0] mainFraction,
   output logic [AUX_W-1:0] auxModulus,
   output logic [AUX_W-1:0] auxFraction,
   output logic activeUpdate,
   // Status
   output logic [3:0] lastSelect
);

   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   if (MAIN_FRAC_W != `MAIN_FRAC_MSB - `MAIN_FRAC_LSB + 1) begin : gMainChk
      $error("main fraction width must match its field");
   end
   if (AUX_W != `AUX_MSB - `AUX_LSB + 1) begin : gAuxChk
      $error("aux word width must match its field");
   end

   // ----------------------------------------
   // Link clock domain
   // ----------------------------------------
   // Quasi-static once the link clock parks; read only on a synced latch edge
   logic [`WORD_W-1:0] shiftWord;

   serial_word_shifter uShifter (
      .serialClock(serialClock),
      .rst(rst),
      .serialData(serialData),
      .shiftWord(shiftWord)
   );

   function automatic logic [3:0] selOf(input logic [`WORD_W-1:0] w);
      selOf = w[`SEL_MSB:`SEL_LSB];
   endfunction : selOf

   function automatic logic [`MAIN_FRAC_MSB-`MAIN_FRAC_LSB:0] mainOf(input logic [`WORD_W-1:0] w);
      mainOf = w[`MAIN_FRAC_MSB:`MAIN_FRAC_LSB];
   endfunction : mainOf

   function automatic logic [`AUX_MSB-`AUX_LSB:0] auxOf(input logic [`WORD_W-1:0] w);
      auxOf = w[`AUX_MSB:`AUX_LSB];
   endfunction : auxOf

   // ----------------------------------------
   // System clock domain
   // ----------------------------------------
   core_state_t r;
   core_state_t rNxt;
   logic leRise;

   always_comb begin
      rNxt = r;
      rNxt.leSync = {r.leSync[0], latchEnable};
      rNxt.lePrev = r.leSync[1];
      leRise = r.leSync[1] && !r.lePrev;
      rNxt.wordValid = leRise;
      rNxt.actUpdate = 1'b0;
      // Link clock is parked while latch enable is high, so the word is stable
      if (leRise) begin
         rNxt.word = shiftWord;
      end
      if (r.wordValid) begin
         rNxt.lastSel = selOf(r.word);
         // Only the field bits are used; reserved positions never reach the buffers
         case (selOf(r.word))
            `SEL_MAIN_FRAC: begin
               rNxt.bufMain = mainOf(r.word);
            end
            `SEL_AUX_MOD: begin
               rNxt.bufAuxMod = auxOf(r.word);
            end
            `SEL_AUX_FRAC: begin
               rNxt.bufAuxFrac = auxOf(r.word);
            end
            `SEL_CONTROL: begin
               // All three words move in the same cycle
               rNxt.actMain = r.bufMain;
               rNxt.actAuxMod = r.bufAuxMod;
               rNxt.actAuxFrac = r.bufAuxFrac;
               rNxt.actUpdate = 1'b1;
            end
            default: begin
               rNxt.actUpdate = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         r <= '{leSync: 2'h0, lePrev: 1'b0, word: `SHIFT_RST, wordValid: 1'b0,
                bufMain: `MAIN_FRAC_RST, bufAuxMod: `AUX_MOD_RST, bufAuxFrac: `AUX_FRAC_RST,
                actMain: `MAIN_FRAC_RST, actAuxMod: `AUX_MOD_RST, actAuxFrac: `AUX_FRAC_RST,
                actUpdate: 1'b0, lastSel: 4'h0};
      end else begin
         r <= rNxt;
      end
   end

   // Numerator parts and second stage denominator to the modulator
   assign mainFraction = r.actMain;
   assign auxModulus = r.actAuxMod;
   assign auxFraction = r.actAuxFrac;
   assign activeUpdate = r.actUpdate;
   assign lastSelect = r.lastSel;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence latchEdge;
      !r.lePrev && r.leSync[1];
   endsequence

   sequence controlWord;
      r.wordValid && selOf(r.word) == `SEL_CONTROL;
   endsequence

   sequence applyAll;
      ##1 activeUpdate ##1 !activeUpdate;
   endsequence

   sequence otherWord;
      r.wordValid && selOf(r.word) > `SEL_AUX_FRAC;
   endsequence

   main_frac_load_a: assert property (
      r.wordValid && selOf(r.word) == `SEL_MAIN_FRAC |=>
         r.bufMain == $past(r.word[`MAIN_FRAC_MSB:`MAIN_FRAC_LSB]) && !activeUpdate)
      else $error("main fraction buffer not loaded");

   numerator_apply_a: assert property (
      activeUpdate |-> mainFraction == $past(r.bufMain) && auxFraction == $past(r.bufAuxFrac))
      else $error("numerator parts not applied together");

   aux_mod_load_a: assert property (
      r.wordValid && selOf(r.word) == `SEL_AUX_MOD |=> r.bufAuxMod == $past(r.word[`AUX_MSB:`AUX_LSB]))
      else $error("aux modulus buffer not loaded");

   aux_mod_hold_a: assert property (
      !(r.wordValid && selOf(r.word) == `SEL_AUX_MOD) |=> $stable(r.bufAuxMod))
      else $error("aux modulus buffer changed without its select");

   denominator_apply_a: assert property (
      activeUpdate |-> auxModulus == $past(r.bufAuxMod))
      else $error("aux modulus not applied");

   aux_frac_load_a: assert property (
      r.wordValid && selOf(r.word) == `SEL_AUX_FRAC |=>
         r.bufAuxFrac == $past(r.word[`AUX_MSB:`AUX_LSB]) && $stable(r.bufMain))
      else $error("aux fraction buffer not loaded");

   aux_frac_hold_a: assert property (
      !(r.wordValid && selOf(r.word) == `SEL_AUX_FRAC) |=> $stable(r.bufAuxFrac))
      else $error("aux fraction buffer changed without its select");

   active_hold_a: assert property (
      !activeUpdate |-> $stable(mainFraction) && $stable(auxModulus) && $stable(auxFraction))
      else $error("active word changed without register 0 write");

   control_apply_a: assert property (
      controlWord |-> applyAll)
      else $error("register 0 write did not apply buffers");

   latch_capture_a: assert property (
      latchEdge |=> r.wordValid [*1] ##1 (!r.wordValid && lastSelect == selOf(r.word)))
      else $error("latched word not decoded");

   main_frac_hold_a: assert property (
      !(r.wordValid && selOf(r.word) == `SEL_MAIN_FRAC) |=> $stable(r.bufMain))
      else $error("main fraction buffer changed without its select");

   select_load_a: assert property (
      r.wordValid |=> lastSelect == $past(r.word[`SEL_MSB:`SEL_LSB]))
      else $error("select code not recorded");

   select_hold_a: assert property (
      !r.wordValid |=> $stable(lastSelect))
      else $error("select code changed without a word");

   control_keep_a: assert property (
      controlWord |=> $stable(r.bufMain) && $stable(r.bufAuxMod) && $stable(r.bufAuxFrac))
      else $error("register 0 write disturbed the buffers");

   update_cause_a: assert property (
      activeUpdate |-> $past(r.wordValid && r.word[`SEL_MSB:`SEL_LSB] == `SEL_CONTROL))
      else $error("update pulse without register 0 write");

   update_single_a: assert property (
      activeUpdate |=> !activeUpdate)
      else $error("update pulse longer than one cycle");

   // Unused select codes must leave every buffer and active word alone
   other_code_a: assert property (
      otherWord |=> !activeUpdate && $stable(r.bufMain) && $stable(r.bufAuxMod) && $stable(r.bufAuxFrac))
      else $error("unused select code changed state");

endmodule : fractional_word_registers

// ---- rtl/fractional_word_consts.svh ----
// Purpose: Constants for the fractional division word registers
// Assumes: 32-bit serial words, MSB first, select code in the low nibble
// Notes:   Definitions only
`ifndef FRACTIONAL_WORD_CONSTS_SVH
`define FRACTIONAL_WORD_CONSTS_SVH

// ----------------------------------------
// Word layout
// ----------------------------------------
`define WORD_W 32
`define SEL_MSB 3
`define SEL_LSB 0
`define MAIN_FRAC_MSB 27
`define MAIN_FRAC_LSB 4
`define AUX_MSB 17
`define AUX_LSB 4

// ----------------------------------------
// Register select codes
// ----------------------------------------
`define SEL_CONTROL 4'h0
`define SEL_MAIN_FRAC 4'h1
`define SEL_AUX_MOD 4'h2
`define SEL_AUX_FRAC 4'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MAIN_FRAC_RST 24'h000000
`define AUX_MOD_RST 14'h0001
`define AUX_FRAC_RST 14'h0000
`define SHIFT_RST 32'h00000000

`endif

// ---- rtl/fractional_word_pkg.sv ----
// Purpose: State types for the fractional division word registers
// Assumes: Widths fixed by the constants header
// Notes:   One packed struct per module
`include "fractional_word_consts.svh"

package fractional_word_pkg;

   typedef struct packed {
      logic [`WORD_W-1:0] shiftWord;
   } link_state_t;

   typedef struct packed {
      logic [1:0] leSync;
      logic lePrev;
      logic [`WORD_W-1:0] word;
      logic wordValid;
      logic [23:0] bufMain;
      logic [13:0] bufAuxMod;
      logic [13:0] bufAuxFrac;
      logic [23:0] actMain;
      logic [13:0] actAuxMod;
      logic [13:0] actAuxFrac;
      logic actUpdate;
      logic [3:0] lastSel;
   } core_state_t;

endpackage : fractional_word_pkg

// ---- rtl/serial_word_shifter.sv ----
// Purpose: Shifts serial data in on the link clock
// Assumes: Host parks the link clock while the latch enable is high
// Notes:   Word is quasi-static once the link clock stops
`timescale 1ns/1ps
`include "fractional_word_consts.svh"

module serial_word_shifter
   import fractional_word_pkg::*;
(
   // Link side
   input wire logic serialClock,
   input wire logic rst,
   input wire logic serialData,
   // To core
   output logic [`WORD_W-1:0] shiftWord
);

   link_state_t r;
   link_state_t rNxt;

   always_comb begin
      rNxt = r;
      rNxt.shiftWord = {r.shiftWord[`WORD_W-2:0], serialData};
   end

   always_ff @(posedge serialClock or posedge rst) begin
      if (rst) begin
         r <= '{shiftWord: `SHIFT_RST};
      end else begin
         r <= rNxt;
      end
   end

   assign shiftWord = r.shiftWord;

endmodule : serial_word_shifter

// ---- tb/host_link_model.sv ----
// Purpose: Host side of the 3-wire link
// Assumes: 80 ns link clock, parked low between frames
// Notes:   Idle data line shows the inverse of the last bit
`timescale 1ns/1ps

module host_link_model (
   // Link
   output logic serialClock,
   output logic serialData,
   output logic latchEnable
);
   initial begin
      serialClock = 1'b0;
      serialData = 1'b0;
      latchEnable = 1'b0;
   end

   // Clock stays parked while latch enable is high, so the word is stable
   task automatic send(input logic [31:0] w);
      #7;
      for (int i = 31; i >= 0; i--) begin
         serialData = w[i];
         #40 serialClock = 1'b1;
         #40 serialClock = 1'b0;
      end
      serialData = ~w[0];
      #100 latchEnable = 1'b1;
      #250 latchEnable = 1'b0;
      #100;
   endtask : send
endmodule : host_link_model

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for the fractional word registers
// Assumes: Host model drives the link, bench drives reset
// Notes:   Integer model of buffered and active words
`timescale 1ns/1ps

module tb;
   logic sys_clk, rst, serialClock, serialData, latchEnable, activeUpdate;
   logic [23:0] mainFraction;
   logic [13:0] auxModulus, auxFraction;
   logic [3:0] lastSelect;
   int fails = 0, cmp_count = 0, seed = 49103, pulses = 0;
   int bMain = 0, bMod = 1, bFrac = 0, aMain = 0, aMod = 1, aFrac = 0;

   fractional_word_registers i_dut (.sys_clk(sys_clk), .rst(rst), .serialClock(serialClock),
      .serialData(serialData), .latchEnable(latchEnable), .mainFraction(mainFraction),
      .auxModulus(auxModulus), .auxFraction(auxFraction), .activeUpdate(activeUpdate),
      .lastSelect(lastSelect));
   host_link_model i_host (.serialClock(serialClock), .serialData(serialData), .latchEnable(latchEnable));

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      if (activeUpdate === 1'b1) pulses++;
   end

   task automatic check(input logic [31:0] got, input int exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   task automatic reset_check;
      @(negedge sys_clk);
      check(auxModulus, 1, "reset modulus");
      check(mainFraction, 0, "reset main");
      check(auxFraction, 0, "reset fraction");
      check(lastSelect, 0, "reset select");
      check(activeUpdate, 0, "reset update");
   endtask : reset_check

   // ----------------------------------------
   // One word over the link, then compare
   // ----------------------------------------
   task automatic write_word(input logic [31:0] w);
      int p;
      p = pulses;
      i_host.send(w);
      case (w[3:0])
         4'h0: begin
            aMain = bMain;
            aMod = bMod;
            aFrac = bFrac;
         end
         4'h1: bMain = w[27:4];
         4'h2: bMod = w[17:4];
         4'h3: bFrac = w[17:4];
         default: ;
      endcase
      check(lastSelect, w[3:0], "select");
      check(pulses - p, int'(w[3:0] == 4'h0), "update pulse");
      check(mainFraction, aMain, "main fraction");
      check(auxModulus, aMod, "aux modulus");
      check(auxFraction, aFrac, "aux fraction");
   endtask : write_word

   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : close_out

   initial begin
      #1ms;
      fails++;
      $display("[FAIL] %0t watchdog expired", $time);
      close_out();
   end

   initial begin
      logic [31:0] w;
      logic [13:0] m;
      rst = 1'b1;
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk) rst = 1'b0;
      reset_check();
      check(pulses, 0, "reset pulse");
      $display("reset test done");
      // Boundary values, reserved bits set, held until the transfer
      write_word(32'hffff_fff1);
      write_word(32'hffff_fff2);
      write_word(32'hfffc_0003);
      write_word(32'h0000_0000);
      write_word(32'h0000_0000);
      $display("boundary test done");
      // Reset in mid-run must clear the buffers as well as the active words
      @(negedge sys_clk) rst = 1'b1;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk) rst = 1'b0;
      bMain = 0;
      bMod = 1;
      bFrac = 0;
      aMain = 0;
      aMod = 1;
      aFrac = 0;
      reset_check();
      write_word(32'h0000_0000);
      $display("midrun reset test done");
      for (int k = 0; k < 12; k++) begin
         w = $random(seed);
         m = (w[17:4] == 14'h0) ? 14'h1 : w[17:4];
         write_word({w[31:18], m, 4'h2});
         w = $random(seed);
         write_word({w[31:18], 14'(w[17:4] % m), 4'h3});
         w = $random(seed);
         write_word({w[31:4], 4'h1});
         w = $random(seed);
         write_word({w[31:4], 4'(4 + k)});
         w = $random(seed);
         write_word({w[31:4], 4'h0});
      end
      $display("random test done");
      close_out();
   end
endmodule : tb
